/* core/ipc_pkg.sv */
// Constants, types and helpers for the input loop configuration register bank
//
// Contract
// - Secondary reference ratio is 10 bits: low byte 0x012, top bits 0x013; 0/1 mean 1.
// - Secondary ratio is used on its own only while loop control bit 7 is set.
// - With that bit clear, secondary reference uses the primary ratio instead.
// - Test reference divider is bits 5..0 at 0x014; 0/1 mean divide by one.
// - Feedback ratio is 10 bits: low byte 0x016, top bits 0x017; 0/1 mean 1.
// - Bit 7 at 0x018 puts the charge pump output in high impedance.
// - Pump current magnitude is bits 6..0 at 0x018, about half a microamp per step.
// - With bit 4 at 0x019 clear the antibacklash period is forced to high.
// - Antibacklash field bits 3..2: minimum, low, high, maximum; resets to high.
// - Pump mode bits 1..0: tristate (reset), pump up, pump down, normal.
// - Bit 7 at 0x01A enables the test reference receiver; disabled after reset.
// - Bits 6 and 5 select differential mode; single-ended pin from 0x01B bits 1..0.
// - Bit 2 clear keeps both receivers on; set lets bits 4 and 3 enable each.
// - Bit 0 selects differential oscillator input; else bit 1 picks negative pin.
package ipc_pkg;

    // -------------------------------------------------------------------------
    // Serial port address map
    // -------------------------------------------------------------------------
    localparam int          IPC_ADDR_W          = 13;
    localparam int          IPC_DATA_W          = 8;
    localparam logic [12:0] IPC_SEC_DIV_LO_OFS  = 13'h0012;
    localparam logic [12:0] IPC_SEC_DIV_HI_OFS  = 13'h0013;
    localparam logic [12:0] IPC_TEST_DIV_OFS    = 13'h0014;
    localparam logic [12:0] IPC_RSVD_OFS        = 13'h0015;
    localparam logic [12:0] IPC_FB_DIV_LO_OFS   = 13'h0016;
    localparam logic [12:0] IPC_FB_DIV_HI_OFS   = 13'h0017;
    localparam logic [12:0] IPC_PUMP_CUR_OFS    = 13'h0018;
    localparam logic [12:0] IPC_ABL_MODE_OFS    = 13'h0019;
    localparam logic [12:0] IPC_RX_CTRL_OFS     = 13'h001A;

    // -------------------------------------------------------------------------
    // Field positions and widths
    // -------------------------------------------------------------------------
    localparam int IPC_DIV10_W        = 10;
    localparam int IPC_DIV6_W         = 6;
    localparam int IPC_CUR_W          = 7;
    localparam int IPC_PUMP_HIZ_BIT   = 7;
    localparam int IPC_ABL_OVR_BIT    = 4;
    localparam int IPC_ABL_LSB        = 2;
    localparam int IPC_MODE_LSB       = 0;
    localparam int IPC_RX_TEST_EN_BIT = 7;
    localparam int IPC_RX_SEC_DIF_BIT = 6;
    localparam int IPC_RX_PRI_DIF_BIT = 5;
    localparam int IPC_RX_SEC_EN_BIT  = 4;
    localparam int IPC_RX_PRI_EN_BIT  = 3;
    localparam int IPC_RX_PD_CTL_BIT  = 2;
    localparam int IPC_RX_OSC_NEG_BIT = 1;
    localparam int IPC_RX_OSC_DIF_BIT = 0;

    // -------------------------------------------------------------------------
    // Values after reset
    // -------------------------------------------------------------------------
    localparam logic [9:0] IPC_SEC_DIV_RST  = 10'h000;
    localparam logic [5:0] IPC_TEST_DIV_RST = 6'h00;
    localparam logic [9:0] IPC_FB_DIV_RST   = 10'h000;
    localparam logic [7:0] IPC_PUMP_CUR_RST = 8'h00;
    localparam logic [4:0] IPC_ABL_MODE_RST = 5'h08;
    localparam logic [7:0] IPC_RX_CTRL_RST  = 8'h00;

    // -------------------------------------------------------------------------
    // Encodings
    // -------------------------------------------------------------------------
    typedef enum logic [1:0] {
        IPC_ABL_MIN  = 2'h0,
        IPC_ABL_LOW  = 2'h1,
        IPC_ABL_HIGH = 2'h2,
        IPC_ABL_MAX  = 2'h3
    } ipc_abl_t;

    typedef enum logic [1:0] {
        IPC_PUMP_TRISTATE = 2'h0,
        IPC_PUMP_UP       = 2'h1,
        IPC_PUMP_DOWN     = 2'h2,
        IPC_PUMP_NORMAL   = 2'h3
    } ipc_pump_mode_t;

    // -------------------------------------------------------------------------
    // Carriers
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [12:0] addr;
        logic [7:0]  wdata;
    } ipc_req_t;

    typedef struct packed {
        logic [9:0] sec_ratio;
        logic [5:0] test_ratio;
        logic [9:0] fb_ratio;
    } ipc_div_t;

    typedef struct packed {
        logic           hiz;
        logic [6:0]     current;
        ipc_pump_mode_t mode;
        ipc_abl_t       abl;
    } ipc_pump_t;

    typedef struct packed {
        logic test_en;
        logic pri_en;
        logic sec_en;
        logic pri_diff;
        logic sec_diff;
        logic pri_se_sel;
        logic sec_se_sel;
        logic osc_diff;
        logic osc_neg_sel;
    } ipc_rx_t;

    // Divide code to ratio: codes zero and one both divide by one
    function automatic logic [9:0] ipc_ratio(input logic [9:0] code);
        ipc_ratio = (code == 10'h000) ? 10'h001 : code;
    endfunction

endpackage

/* core/ipc_rx_decode.sv */
// Decoder for the reference, test and oscillator input receiver controls
`timescale 1ns/1ps
`default_nettype none
module ipc_rx_decode
    import ipc_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       resetn_i,
    input  wire logic [7:0] rx_ctrl_i,
    input  wire logic [1:0] se_pin_sel_i,
    output var  ipc_rx_t    rx_o
);

    ipc_rx_t rx_d;
    ipc_rx_t rx_q;

    // -------------------------------------------------------------------------
    // Receiver state decode
    // -------------------------------------------------------------------------
    always_comb begin
        rx_d.test_en     = rx_ctrl_i[IPC_RX_TEST_EN_BIT];
        rx_d.pri_en      = ~rx_ctrl_i[IPC_RX_PD_CTL_BIT] | rx_ctrl_i[IPC_RX_PRI_EN_BIT];
        rx_d.sec_en      = ~rx_ctrl_i[IPC_RX_PD_CTL_BIT] | rx_ctrl_i[IPC_RX_SEC_EN_BIT];
        rx_d.pri_diff    = rx_ctrl_i[IPC_RX_PRI_DIF_BIT];
        rx_d.sec_diff    = rx_ctrl_i[IPC_RX_SEC_DIF_BIT];
        // Pin choice means nothing in differential mode, so it reads zero there
        rx_d.pri_se_sel  = ~rx_ctrl_i[IPC_RX_PRI_DIF_BIT] & se_pin_sel_i[0];
        rx_d.sec_se_sel  = ~rx_ctrl_i[IPC_RX_SEC_DIF_BIT] & se_pin_sel_i[1];
        rx_d.osc_diff    = rx_ctrl_i[IPC_RX_OSC_DIF_BIT];
        rx_d.osc_neg_sel = ~rx_ctrl_i[IPC_RX_OSC_DIF_BIT] & rx_ctrl_i[IPC_RX_OSC_NEG_BIT];
    end

    // Register so the analog controls never see decode glitches
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            rx_q <= '{test_en: 1'b0, pri_en: 1'b1, sec_en: 1'b1, default: 1'b0};
        end else begin
            rx_q <= rx_d;
        end
    end

    assign rx_o = rx_q;

endmodule
`default_nettype wire

/* core/ipc_regs.sv */
// Input loop configuration register bank behind the serial control port
`timescale 1ns/1ps
`default_nettype none
module ipc_regs
    import ipc_pkg::*;
(
    input  wire logic       clock_i,         // Serial port clock
    input  wire logic       resetn_i,        // Synchronous, active low
    input  wire ipc_req_t   reg_req_i,       // Byte access from the serial port engine
    output var  logic [7:0] reg_rdata_o,     // Read data, held until next read
    output var  logic       reg_rvalid_o,    // One-cycle pulse with read data
    input  wire logic [9:0] pri_div_code_i,  // Primary reference divide code
    input  wire logic       sec_indep_i,     // Secondary divider independence bit
    input  wire logic [1:0] se_pin_sel_i,    // Single-ended pin choices, secondary and primary
    output var  ipc_div_t   div_o,           // Effective divide ratios
    output var  ipc_pump_t  pump_o,          // Effective charge pump controls
    output var  ipc_rx_t    rx_o             // Receiver enables and modes
);

    // -------------------------------------------------------------------------
    // Stored fields
    // -------------------------------------------------------------------------
    logic [9:0] sec_div_q;
    logic [9:0] sec_div_d;
    logic [5:0] test_div_q;
    logic [5:0] test_div_d;
    logic [9:0] fb_div_q;
    logic [9:0] fb_div_d;
    logic [7:0] pump_cur_q;
    logic [7:0] pump_cur_d;
    logic [4:0] abl_mode_q;
    logic [4:0] abl_mode_d;
    logic [7:0] rx_ctrl_q;
    logic [7:0] rx_ctrl_d;

    // Write decode: only implemented bits are stored, reserved bits are dropped
    always_comb begin
        sec_div_d  = sec_div_q;
        test_div_d = test_div_q;
        fb_div_d   = fb_div_q;
        pump_cur_d = pump_cur_q;
        abl_mode_d = abl_mode_q;
        rx_ctrl_d  = rx_ctrl_q;
        if (reg_req_i.wr) begin
            unique case (reg_req_i.addr)
                IPC_SEC_DIV_LO_OFS: begin
                    sec_div_d[7:0] = reg_req_i.wdata;
                end
                IPC_SEC_DIV_HI_OFS: begin
                    sec_div_d[9:8] = reg_req_i.wdata[1:0];
                end
                IPC_TEST_DIV_OFS: begin
                    test_div_d = reg_req_i.wdata[IPC_DIV6_W-1:0];
                end
                IPC_FB_DIV_LO_OFS: begin
                    fb_div_d[7:0] = reg_req_i.wdata;
                end
                IPC_FB_DIV_HI_OFS: begin
                    fb_div_d[9:8] = reg_req_i.wdata[1:0];
                end
                IPC_PUMP_CUR_OFS: begin
                    pump_cur_d = reg_req_i.wdata;
                end
                IPC_ABL_MODE_OFS: begin
                    abl_mode_d = reg_req_i.wdata[4:0];
                end
                IPC_RX_CTRL_OFS: begin
                    rx_ctrl_d = reg_req_i.wdata;
                end
                default: begin
                    // reserved byte and foreign addresses ignore writes
                    sec_div_d = sec_div_q;
                end
            endcase
        end
    end

    // Field registers
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            sec_div_q  <= IPC_SEC_DIV_RST;
            test_div_q <= IPC_TEST_DIV_RST;
            fb_div_q   <= IPC_FB_DIV_RST;
            pump_cur_q <= IPC_PUMP_CUR_RST;
            abl_mode_q <= IPC_ABL_MODE_RST;
            rx_ctrl_q  <= IPC_RX_CTRL_RST;
        end else begin
            sec_div_q  <= sec_div_d;
            test_div_q <= test_div_d;
            fb_div_q   <= fb_div_d;
            pump_cur_q <= pump_cur_d;
            abl_mode_q <= abl_mode_d;
            rx_ctrl_q  <= rx_ctrl_d;
        end
    end

    // -------------------------------------------------------------------------
    // Read back
    // -------------------------------------------------------------------------
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       rvalid_q;
    logic       rvalid_d;

    // A read in the same cycle as a write returns the old value
    always_comb begin
        rdata_d  = rdata_q;
        rvalid_d = reg_req_i.rd;
        if (reg_req_i.rd) begin
            unique case (reg_req_i.addr)
                IPC_SEC_DIV_LO_OFS: rdata_d = sec_div_q[7:0];
                IPC_SEC_DIV_HI_OFS: rdata_d = {6'h00, sec_div_q[9:8]};
                IPC_TEST_DIV_OFS:   rdata_d = {2'h0, test_div_q};
                IPC_FB_DIV_LO_OFS:  rdata_d = fb_div_q[7:0];
                IPC_FB_DIV_HI_OFS:  rdata_d = {6'h00, fb_div_q[9:8]};
                IPC_PUMP_CUR_OFS:   rdata_d = pump_cur_q;
                IPC_ABL_MODE_OFS:   rdata_d = {3'h0, abl_mode_q};
                IPC_RX_CTRL_OFS:    rdata_d = rx_ctrl_q;
                default:            rdata_d = 8'h00;
            endcase
        end
    end

    // Read data holding registers
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign reg_rdata_o  = rdata_q;
    assign reg_rvalid_o = rvalid_q;

    // -------------------------------------------------------------------------
    // Effective divider ratios
    // -------------------------------------------------------------------------
    ipc_div_t div_q;
    ipc_div_t div_d;

    // Ratios, not codes, go out so the dividers need no zero special case
    always_comb begin
        if (sec_indep_i) begin
            div_d.sec_ratio = ipc_ratio(sec_div_q);
        end else begin
            div_d.sec_ratio = ipc_ratio(pri_div_code_i);
        end
        // test ratio, zero maps to one
        div_d.test_ratio = IPC_DIV6_W'(ipc_ratio({4'h0, test_div_q}));
        div_d.fb_ratio   = ipc_ratio(fb_div_q);
    end

    // Divider ratio outputs
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            div_q <= '{sec_ratio: 10'h001, test_ratio: 6'h01, fb_ratio: 10'h001};
        end else begin
            div_q <= div_d;
        end
    end

    assign div_o = div_q;

    // -------------------------------------------------------------------------
    // Effective charge pump controls
    // -------------------------------------------------------------------------
    ipc_pump_t pump_q;
    ipc_pump_t pump_d;

    always_comb begin
        pump_d.hiz     = pump_cur_q[IPC_PUMP_HIZ_BIT];
        pump_d.current = pump_cur_q[IPC_CUR_W-1:0];
        pump_d.mode    = ipc_pump_mode_t'(abl_mode_q[IPC_MODE_LSB +: 2]);
        if (abl_mode_q[IPC_ABL_OVR_BIT]) begin
            pump_d.abl = ipc_abl_t'(abl_mode_q[IPC_ABL_LSB +: 2]);
        end else begin
            pump_d.abl = IPC_ABL_HIGH;
        end
    end

    // Pump control outputs; reset state is a tristated pump at high width
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            pump_q <= '{hiz: 1'b0, current: 7'h00, mode: IPC_PUMP_TRISTATE, abl: IPC_ABL_HIGH};
        end else begin
            pump_q <= pump_d;
        end
    end

    assign pump_o = pump_q;

    // -------------------------------------------------------------------------
    // Receiver controls
    // -------------------------------------------------------------------------
    // Output of this instance is registered inside it
    ipc_rx_decode u_rx_decode (
        .clock_i      (clock_i),
        .resetn_i     (resetn_i),
        .rx_ctrl_i    (rx_ctrl_q),
        .se_pin_sel_i (se_pin_sel_i),
        .rx_o         (rx_o)
    );

endmodule
`default_nettype wire

/* dv/ipc_regs_asserts.sv */
// Checker for the input loop configuration register bank
`timescale 1ns/1ps
`default_nettype none
module ipc_regs_asserts
    import ipc_pkg::*;
(
    input wire logic       clock_i,
    input wire logic       resetn_i,
    input wire ipc_req_t   reg_req_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       reg_rvalid_o,
    input wire logic [9:0] pri_div_code_i,
    input wire logic       sec_indep_i,
    input wire logic [1:0] se_pin_sel_i,
    input wire ipc_div_t   div_o,
    input wire ipc_pump_t  pump_o,
    input wire ipc_rx_t    rx_o
);
    // ---------------------------------------------------------------
    // Sequences
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    // A write not overwritten at the next edge, so its value reaches the outputs
    sequence s_wr_once(logic [12:0] a);
        reg_req_i.wr && reg_req_i.addr == a ##1 !(reg_req_i.wr && reg_req_i.addr == a);
    endsequence

    // Primary code held for two edges while the secondary follows it
    sequence s_pri_held;
        !sec_indep_i && pri_div_code_i > 10'h001 ##1 !sec_indep_i && $stable(pri_div_code_i);
    endsequence

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    a_read_answer: assert property (reg_req_i.rd |=> reg_rvalid_o)
        else $error("read not answered one cycle later");
    a_no_spurious_valid: assert property (!reg_req_i.rd |=> !reg_rvalid_o)
        else $error("read valid without a read");
    a_reserved_zero: assert property (reg_req_i.rd && reg_req_i.addr == IPC_RSVD_OFS |=> reg_rdata_o == 8'h00)
        else $error("reserved byte read not zero");
    a_pump_fields: assert property (s_wr_once(IPC_PUMP_CUR_OFS) |=>
        {pump_o.hiz, pump_o.current} == $past(reg_req_i.wdata, 2))
        else $error("pump tristate or current wrong");
    a_abl_forced: assert property (!reg_req_i.wdata[4] ##0 s_wr_once(IPC_ABL_MODE_OFS) |=>
        pump_o.abl == IPC_ABL_HIGH)
        else $error("antibacklash not forced high");
    a_abl_programmed: assert property (reg_req_i.wdata[4] ##0 s_wr_once(IPC_ABL_MODE_OFS) |=>
        pump_o.abl == $past(reg_req_i.wdata[3:2], 2))
        else $error("antibacklash field not applied");
    a_pump_mode: assert property (s_wr_once(IPC_ABL_MODE_OFS) |=>
        pump_o.mode == $past(reg_req_i.wdata[1:0], 2))
        else $error("pump mode wrong");
    a_test_rx_enable: assert property (s_wr_once(IPC_RX_CTRL_OFS) |=>
        rx_o.test_en == $past(reg_req_i.wdata[7], 2))
        else $error("test receiver enable wrong");
    a_rx_power_gate: assert property (s_wr_once(IPC_RX_CTRL_OFS) |=>
        rx_o.pri_en == (!$past(reg_req_i.wdata[2], 2) || $past(reg_req_i.wdata[3], 2))
        && rx_o.sec_en == (!$past(reg_req_i.wdata[2], 2) || $past(reg_req_i.wdata[4], 2)))
        else $error("reference receiver enable wrong");
    a_osc_select: assert property (s_wr_once(IPC_RX_CTRL_OFS) |=>
        rx_o.osc_diff == $past(reg_req_i.wdata[0], 2)
        && rx_o.osc_neg_sel == ($past(reg_req_i.wdata[1:0], 2) == 2'h2))
        else $error("oscillator receiver mode wrong");
    a_sec_follows_pri: assert property (s_pri_held |-> div_o.sec_ratio == pri_div_code_i)
        else $error("secondary ratio not following primary");
    a_diff_no_se: assert property (rx_o.pri_diff || rx_o.sec_diff |->
        !(rx_o.pri_diff && rx_o.pri_se_sel) && !(rx_o.sec_diff && rx_o.sec_se_sel))
        else $error("single-ended select while differential");
endmodule

bind ipc_regs ipc_regs_asserts i_asserts (.clock_i, .resetn_i, .reg_req_i, .reg_rdata_o, .reg_rvalid_o,
    .pri_div_code_i, .sec_indep_i, .se_pin_sel_i, .div_o, .pump_o, .rx_o);
`default_nettype wire

/* dv/input_pll_config_registers_tb_top.sv */
// Self-checking testbench for the input loop configuration register bank
`timescale 1ns/1ps
`default_nettype none
module input_pll_config_registers_tb_top;
    import ipc_pkg::*;

    // ---------------------------------------------------------------
    // Signals and tables
    // ---------------------------------------------------------------
    logic       clock_i         = 1'b0;
    logic       resetn_i        = 1'b0;
    ipc_req_t   req             = '0;
    logic [7:0] rdata;
    logic       rvalid;
    logic [9:0] pri_code        = 10'h000;
    logic       indep           = 1'b0;
    logic [1:0] se_sel          = 2'h0;
    ipc_div_t   div;
    ipc_pump_t  pump;
    ipc_rx_t    rx;
    int         num_errors      = 0;
    int         samples_checked = 0;
    // Writable bits per offset 0x012 to 0x01A
    logic [7:0] masks [9]       = '{8'hFF, 8'h03, 8'h3F, 8'h00, 8'hFF, 8'h03, 8'hFF, 8'h1F, 8'hFF};
    logic [7:0] rx_vals [8]     = '{8'h14, 8'h0C, 8'h84, 8'h60, 8'h02, 8'h03, 8'h00, 8'h9B};

    always #5 clock_i = ~clock_i;

    ipc_regs i_dut (.clock_i(clock_i), .resetn_i(resetn_i), .reg_req_i(req), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .pri_div_code_i(pri_code), .sec_indep_i(indep), .se_pin_sel_i(se_sel),
        .div_o(div), .pump_o(pump), .rx_o(rx));

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic compare(input string name, input logic [25:0] exp, input logic [25:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One request cycle, released right after the edge that takes it
    task automatic access(input logic wr, input logic rd, input logic [12:0] a, input logic [7:0] d);
        @(posedge clock_i);
        #1 req = '{wr, rd, a, d};
        @(posedge clock_i);
        #1 req = '0;
    endtask

    task automatic wr_reg(input logic [12:0] a, input logic [7:0] d);
        access(1'b1, 1'b0, a, d);
    endtask

    // Read data and valid are looked at in the one cycle that valid stands
    task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
        access(1'b0, 1'b1, a, 8'h00);
        compare("read valid", 26'h1, {25'h0, rvalid});
        compare("read data", {18'h0, exp}, {18'h0, rdata});
    endtask

    // Fields reach the decoded outputs one edge after they change
    task automatic settle();
        repeat (2) @(posedge clock_i);
        #1;
    endtask

    function automatic logic [8:0] rx_exp(input logic [7:0] v, input logic [1:0] s);
        return {v[7], !v[2] | v[3], !v[2] | v[4], v[5], v[6], !v[5] & s[0], !v[6] & s[1], v[0], !v[0] & v[1]};
    endfunction

    task automatic final_report();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog at 20000 cycles, far beyond the fewer than two hundred cycles the tests need
    initial begin
        #200000;
        num_errors++;
        final_report();
    end

    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clock_i);
        #1 resetn_i = 1'b1;
        for (int i = 0; i < 9; i++) rd_chk(IPC_SEC_DIV_LO_OFS + 13'(i), (i == 7) ? 8'h08 : 8'h00);
        compare("div", {10'h001, 6'h01, 10'h001}, div);
        compare("pump", {14'h0, 1'b0, 7'h00, 2'h0, 2'h2}, pump);
        compare("rx", 26'h0C0, rx);
        // Full-scale writes everywhere, unused bits must drop
        for (int i = 0; i < 9; i++) wr_reg(IPC_SEC_DIV_LO_OFS + 13'(i), 8'hFF);
        wr_reg(13'h001C, 8'hFF);
        for (int i = 0; i < 9; i++) rd_chk(IPC_SEC_DIV_LO_OFS + 13'(i), masks[i]);
        rd_chk(13'h001C, 8'h00);
        indep = 1'b1;
        settle();
        compare("div", {10'h3FF, 6'h3F, 10'h3FF}, div);
        compare("pump", {14'h0, 1'b1, 7'h7F, 2'h3, 2'h3}, pump);
        // Codes one and zero both divide by one
        wr_reg(IPC_SEC_DIV_LO_OFS, 8'h34);
        wr_reg(IPC_SEC_DIV_HI_OFS, 8'h02);
        wr_reg(IPC_TEST_DIV_OFS, 8'h01);
        wr_reg(IPC_FB_DIV_LO_OFS, 8'h00);
        wr_reg(IPC_FB_DIV_HI_OFS, 8'h00);
        settle();
        compare("div", {10'h234, 6'h01, 10'h001}, div);
        // Secondary falls back to the primary code once independence is cleared
        indep = 1'b0;
        pri_code = 10'h155;
        wr_reg(IPC_TEST_DIV_OFS, 8'h00);
        wr_reg(IPC_FB_DIV_LO_OFS, 8'h01);
        wr_reg(IPC_FB_DIV_HI_OFS, 8'h02);
        settle();
        compare("div", {10'h155, 6'h01, 10'h201}, div);
        wr_reg(IPC_PUMP_CUR_OFS, 8'h85);
        settle();
        compare("pump", {14'h0, 1'b1, 7'h05, 2'h3, 2'h3}, pump);
        // Every mode and width code, with the width override off and on
        for (int m = 0; m < 8; m++) begin
            wr_reg(IPC_ABL_MODE_OFS, {3'h0, m[2], ~m[1:0], m[1:0]});
            settle();
            compare("pump", {14'h0, 1'b1, 7'h05, m[1:0], m[2] ? ~m[1:0] : 2'h2}, pump);
        end
        for (int i = 0; i < 8; i++) begin
            se_sel = i[1:0];
            wr_reg(IPC_RX_CTRL_OFS, rx_vals[i]);
            settle();
            compare("rx", {17'h0, rx_exp(rx_vals[i], i[1:0])}, rx);
        end
        // Reset in mid-run restores the defaults
        @(posedge clock_i);
        #1 resetn_i = 1'b0;
        repeat (2) @(posedge clock_i);
        #1 resetn_i = 1'b1;
        // Outputs still hold their reset values before the first edge after release
        compare("div", {10'h001, 6'h01, 10'h001}, div);
        compare("pump", {14'h0, 1'b0, 7'h00, 2'h0, 2'h2}, pump);
        compare("rx", 26'h0C0, rx);
        rd_chk(IPC_ABL_MODE_OFS, 8'h08);
        rd_chk(IPC_RX_CTRL_OFS, 8'h00);
        compare("div", {10'h155, 6'h01, 10'h001}, div);
        final_report();
    end
endmodule
`default_nettype wire
